// File: design/rtc_timer.v
// Chosen here: the strobed register port.
`default_nettype none
`include "rtc_map.vh"
// Functional notes
// - 24-bit writable load value, upper byte zero
// - Live count readable, upper byte zero
// - Control bit 2 masks interrupt when set
// - Control bit 1 selects free-run or reload
// - Control bit 0 enables, bits 31:3 zero
// - Clear register reads zero, clears interrupt
// - Enable zero stops the counter
module rtc_timer (
  input wire clk, // 100 MHz clock
  input wire reset, // Async reset, high
  input wire ce, // Clock enable, freezes state
  input wire [7:0] addr, // Byte address
  input wire [31:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [31:0] rdata_q, // Read data, cycle after rd
  output wire irq // Level interrupt
);
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [23:0] load_q;
  reg en_q;
  reg mode_q;
  reg mask_q;
  reg pend_q;
  reg imask_q;
  reg start_q;
  wire [23:0] live;
  wire expire;
  wire wr_ctrl;
  wire rd_clr;
  wire wr_stat;
  // Decode strobes
  assign wr_ctrl = wr & (addr == `RTC_OFF_CTRL);
  assign rd_clr = rd & (addr == `RTC_OFF_ICLR);
  assign wr_stat = wr & (addr == `RTC_OFF_ISTAT) & wdata[0];
  // Writable registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      load_q <= `RTC_LOAD_RST;
      en_q <= 1'b0;
      mode_q <= 1'b0;
      mask_q <= 1'b0;
      imask_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= wr_ctrl & wdata[`RTC_CTRL_EN] & ~en_q;
      if (wr && addr == `RTC_OFF_LOAD) begin
        load_q <= wdata[23:0];
      end
      if (wr_ctrl) begin
        en_q <= wdata[`RTC_CTRL_EN];
        mode_q <= wdata[`RTC_CTRL_MODE];
        mask_q <= wdata[`RTC_CTRL_MASK];
      end
      if (wr && addr == `RTC_OFF_IMASK) begin
        imask_q <= wdata[0];
      end
    end
  end
  // Sticky pending bit, set wins over clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      if (expire) begin
        pend_q <= 1'b1;
      end else if (rd_clr || wr_stat) begin
        pend_q <= 1'b0;
      end
    end
  end
  // Counter core
  rtc_down_counter #(
    .W(`RTC_CNT_W)
  ) u_cnt (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .run(en_q),
    .user_mode(mode_q),
    .load(load_q),
    .start(start_q),
    .count_q(live),
    .expire(expire)
  );
  // Interrupt gating
  assign irq = pend_q & ~mask_q & ~imask_q;
  // Read data
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      rdata_q <= 32'h00000000;
      if (rd) begin
        if (addr == `RTC_OFF_LOAD) begin
          rdata_q <= {8'h00, load_q};
        end else if (addr == `RTC_OFF_LIVE) begin
          rdata_q <= {8'h00, live};
        end else if (addr == `RTC_OFF_CTRL) begin
          rdata_q <= {29'h00000000, mask_q, mode_q, en_q};
        end else if (addr == `RTC_OFF_ICLR) begin
          rdata_q <= 32'h00000000;
        end else if (addr == `RTC_OFF_ISTAT) begin
          rdata_q <= {31'h00000000, pend_q};
        end else if (addr == `RTC_OFF_IMASK) begin
          rdata_q <= {31'h00000000, imask_q};
        end
      end
    end
  end
endmodule // rtc_timer
`default_nettype wire

// File: shared/rtc_map.vh
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTC_OFF_LOAD 8'h14
`define RTC_OFF_LIVE 8'h18
`define RTC_OFF_CTRL 8'h1C
`define RTC_OFF_ICLR 8'h20
`define RTC_OFF_ISTAT 8'h24
`define RTC_OFF_IMASK 8'h28
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RTC_CTRL_EN 0
`define RTC_CTRL_MODE 1
`define RTC_CTRL_MASK 2
`define RTC_CNT_W 24
`define RTC_LOAD_RST 24'h000000
`define RTC_CTRL_RST 3'h0
`endif

// File: design/rtc_down_counter.v
`default_nettype none
`include "rtc_map.vh"
// ----------------------------------------------------------------------
// Down counter with reload or wrap
// ----------------------------------------------------------------------
module rtc_down_counter #(
  parameter W = 24
) (
  input wire clk, // Clock
  input wire reset, // Async reset, high
  input wire ce, // Clock enable
  input wire run, // Count enable
  input wire user_mode, // 1 reload from load, 0 wrap to max
  input wire [W-1:0] load, // Reload value
  input wire start, // Load counter now
  output reg [W-1:0] count_q, // Live count
  output wire expire // Expiry pulse
);
  reg [W-1:0] count_d;
  // Expiry when counting through zero
  assign expire = ce & run & ~start & (count_q == {W{1'b0}});
  // Next count
  always @* begin
    count_d = count_q;
    if (start) begin
      count_d = load;
    end else if (run) begin
      if (count_q == {W{1'b0}}) begin
        count_d = user_mode ? load : {W{1'b1}};
      end else begin
        count_d = count_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  // Count register
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= {W{1'b0}};
    end else if (ce) begin
      count_q <= count_d;
    end
  end
endmodule // rtc_down_counter
`default_nettype wire

// File: tb/rtc_timer_assertions.sv
`default_nettype none
module rtc_chk (
  input wire clk, // Clock
  input wire reset, // Reset
  input wire ce, // Clock enable
  input wire [7:0] addr, // Address
  input wire [31:0] wdata, // Data
  input wire wr, // Write
  input wire rd, // Read
  input wire [31:0] rdata_q, // Read data
  input wire irq // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_LD: assert property (rd && addr == 8'h14 |=> !rdata_q[31:24])
    else $error("load top");
  AST_LV: assert property (rd && addr == 8'h18 |=> !rdata_q[31:24])
    else $error("live top");
  AST_CT: assert property (rd && addr == 8'h1C |=> !rdata_q[31:3])
    else $error("ctrl top");
  AST_EOI: assert property (rd && addr == 8'h20 |=> !rdata_q)
    else $error("clear data");
  AST_IDL: assert property (ce && !rd |=> !rdata_q)
    else $error("idle data");
  AST_MSK: assert property (wr && addr == 8'h1C && wdata[2] |=> !irq)
    else $error("masked irq");
  AST_CLR: assert property (wr && addr == 8'h1C && !wdata[0] ##2
    rd && addr == 8'h20 |=> ##1 !irq) else $error("irq kept");
  AST_EXP: assert property (wr && addr == 8'h1C && wdata[2:0] == 3'h3
    |-> ##[1:40] irq) else $error("no expiry");
  cover property (irq);
  cover property (rd && addr == 8'h20 && irq);
  cover property (wr && addr == 8'h1C && wdata[0]);
endmodule // rtc_chk
bind rtc_timer rtc_chk rtc_chk_inst (.*);
`default_nettype wire

// File: tb/tb_rtc_timer.sv
`default_nettype none
module tb_rtc_timer;
  timeunit 1ns / 1ns;
  logic clk = 1'h0, reset = 1'h1, wr = 1'h0, rd = 1'h0, ce = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, u;
  wire [31:0] rdata_q;
  wire irq;
  int n_errors = 0, comparisons = 0, seed = 32'h05646d9e;
  always #5 clk = ~clk;
  rtc_timer rtc_timer_inst (.clk, .reset, .ce, .addr, .wdata, .wr,
    .rd, .rdata_q, .irq);
  task chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) $display("Error read exp %h seen %h", e, s);
    n_errors += int'(s !== e);
  endtask
  task acc(input logic [7:0] a, input logic [31:0] d, m = 32'h0, e = 32'h0);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {m == 32'h0, m != 32'h0, a, d};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1 if (m != 32'h0) chk((rdata_q | {irq, 31'h0}) & m, e);
  endtask
  task print_verdict(input int late);
    n_errors += late;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial #40000 print_verdict(1);
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    for (int i = 5; i < 17; i++)
      acc(8'(4 * i), 32'h0, ~32'h0, 32'h0);
    repeat (8) begin
      u = $random(seed);
      acc(8'h14, u);
      acc(8'h14, 32'h0, ~32'h0, {8'h00, u[23:0]});
    end
    acc(8'h14, 32'h5);
    acc(8'h1C, 32'h3);
    repeat (20) @(posedge clk);
    acc(8'h18, 32'h0, 32'h80FFFFF8, 32'h80000000);
    acc(8'h1C, 32'h7);
    acc(8'h1C, 32'h0, ~32'h0, 32'h7);
    acc(8'h1C, 32'h0);
    acc(8'h20, 32'h0, ~32'h0, 32'h0);
    acc(8'h1C, 32'h1);
    repeat (9) @(posedge clk);
    acc(8'h18, 32'h0, 32'h80F00000, 32'h80F00000);
    // Clock enable low for four edges freezes the count
    @(posedge clk);
    ce <= 1'h0;
    repeat (4) @(posedge clk);
    ce <= 1'h1;
    acc(8'h18, 32'h0, ~32'h0, 32'h80FFFFF9);
    // Extra mask hides the interrupt, status write clears it
    acc(8'h28, 32'h1);
    acc(8'h28, 32'h0, ~32'h0, 32'h1);
    acc(8'h28, 32'h0);
    acc(8'h24, 32'h1);
    acc(8'h24, 32'h0, ~32'h0, 32'h0);
    print_verdict(0);
  end
endmodule // tb_rtc_timer
`default_nettype wire
